// File: hdl/aesc_top.sv
// aes-128 block engine with ahb-lite registers, interrupt and dma trigger
// Function
// (RULE_01) encrypt or decrypt one block, 128-bit key
// (RULE_02) software loads key and state before start
// (RULE_03) completion 375 cycles after start
// (RULE_04) result readable, interrupt when enabled
// (RULE_05) dma trigger on every completion
// (RULE_06) auto start after last state byte
// (RULE_07) xor load mode combines written bytes
// (RULE_08) byte ports with self-advancing pointers
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module aesc_top (
  input wire logic CORE_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic HSEL_IN,
  input wire logic [aesc_pkg::BUS_W-1:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [aesc_pkg::BUS_W-1:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [aesc_pkg::BUS_W-1:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic IRQ_OUT,
  output logic DMA_TRIG_OUT
);
  import aesc_pkg::*;

  // address match, used by every strobe
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr == ofs;
  endfunction : hit

  // bus data phase
  logic dp_vld_q, dp_vld_d; // a word transfer is in data phase
  logic dp_wr_q, dp_wr_d; // it is a write
  logic [7:0] dp_adr_q, dp_adr_d; // its register offset
  logic [31:0] rdata_q, rdata_d; // read data, captured at address phase
  // software controls and events
  logic dec_q, dec_d; // decrypt mode
  logic auto_q, auto_d; // auto start
  logic xor_q, xor_d; // xor load mode
  logic [1:0] ev_q, ev_d; // sticky events
  logic [1:0] msk_q, msk_d; // interrupt enables
  logic trig_q, trig_d; // dma trigger pulse
  // engine
  aesc_state_t fsm_q, fsm_d;
  logic [127:0] st_q, st_d; // state memory and working block
  logic [127:0] key_q, key_d; // key memory, kept across operations
  logic [127:0] rk_q, rk_d; // current round key
  logic [3:0] rnd_q, rnd_d; // round number
  logic [3:0] sp_q, sp_d; // state byte pointer
  logic [3:0] kp_q, kp_d; // key byte pointer
  logic [8:0] cyc_q, cyc_d; // cycles since start
  logic run_dec_q, run_dec_d; // direction latched at start

  logic ap_take; // address phase accepted
  logic busy;
  logic wr_ctrl, wr_sts, wr_msk, wr_st, wr_key, rd_st;
  logic go, done_ev, err_ev;
  logic go_dec; // direction taken at start, from a start control write itself, else from the mode register
  logic [7:0] st_byte; // byte under the state pointer
  logic [7:0] xor_byte; // that byte combined with write data
  logic last;
  logic [127:0] rnd_out, rk_fwd, rk_bwd, rk_nx;
  logic [31:0] w0, w1, w2, w3, gw, sw, g;

  // only whole-word transfers are acted on; others answer okay, no effect
  assign ap_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN &&
                   HSIZE_IN == SIZE_WORD;
  assign busy = fsm_q != S_IDLE;
  assign wr_ctrl = dp_vld_q && dp_wr_q && hit(dp_adr_q, OFS_CTRL);
  assign wr_sts = dp_vld_q && dp_wr_q && hit(dp_adr_q, OFS_STATUS);
  assign wr_msk = dp_vld_q && dp_wr_q && hit(dp_adr_q, OFS_MASK);
  assign wr_st = dp_vld_q && dp_wr_q && hit(dp_adr_q, OFS_STATE);
  assign wr_key = dp_vld_q && dp_wr_q && hit(dp_adr_q, OFS_KEY);
  assign rd_st = ap_take && !HWRITE_IN && hit(HADDR_IN[7:0], OFS_STATE);
  assign st_byte = st_q[{~sp_q, 3'b000} +: 8];
  assign xor_byte = st_byte ^ HWDATA_IN[7:0];
  // explicit start or the last state byte in auto mode
  assign go = !busy && ((wr_ctrl && HWDATA_IN[CTRL_START_BIT]) ||
              (wr_st && auto_q && sp_q == 4'hf)); // see RULE_06
  assign done_ev = fsm_q == S_HOLD && cyc_q == OP_LAST; // see RULE_03
  // the register still holds the old mode while its write lands
  assign go_dec = wr_ctrl ? HWDATA_IN[CTRL_DEC_BIT] : dec_q; // see RULE_01
  // memory or control touched mid-operation
  assign err_ev = busy && (wr_ctrl || wr_st || wr_key || rd_st);

  // key schedule: the inverse step feeds w3^w2 through the same boxes
  assign w0 = rk_q[127:96];
  assign w1 = rk_q[95:64];
  assign w2 = rk_q[63:32];
  assign w3 = rk_q[31:0];
  assign gw = (run_dec_q && fsm_q == S_RUN) ? (w3 ^ w2) : w3;
  for (genvar j = 0; j < 4; j++) begin : g_ksub
    aesc_sbox u_ksbox (
      .byte_in(gw[31-8*j -: 8]),
      .inv_in(1'b0),
      .byte_out(sw[31-8*j -: 8])
    );
  end
  assign g = {sw[23:0], sw[31:24]} ^ {rcon(rnd_q), 24'h000000};
  assign rk_fwd[127:96] = w0 ^ g;
  assign rk_fwd[95:64] = w1 ^ w0 ^ g;
  assign rk_fwd[63:32] = w2 ^ w1 ^ w0 ^ g;
  assign rk_fwd[31:0] = w3 ^ w2 ^ w1 ^ w0 ^ g;
  assign rk_bwd = {w0 ^ g, w1 ^ w0, w2 ^ w1, w3 ^ w2};
  assign rk_nx = run_dec_q ? rk_bwd : rk_fwd;
  assign last = run_dec_q ? rnd_q == FIRST_ROUND : rnd_q == LAST_ROUND;

  aesc_round u_round (
    .state_in(st_q),
    .key_in(rk_nx),
    .dec_in(run_dec_q),
    .last_in(last),
    .state_out(rnd_out)
  );

  // bus phase tracking and read capture
  always_comb begin
    dp_vld_d = ap_take;
    dp_wr_d = ap_take && HWRITE_IN;
    dp_adr_d = ap_take ? HADDR_IN[7:0] : dp_adr_q;
    rdata_d = rdata_q;
    if (ap_take && !HWRITE_IN) begin
      rdata_d = 32'h00000000; // unmapped reads as zero
      case (HADDR_IN[7:0])
        OFS_CTRL: begin
          rdata_d[CTRL_DEC_BIT] = dec_q;
          rdata_d[CTRL_AUTO_BIT] = auto_q;
          rdata_d[CTRL_XOR_BIT] = xor_q;
        end
        OFS_STATUS: begin
          rdata_d[1:0] = ev_q;
          rdata_d[STS_BUSY_BIT] = busy;
        end
        OFS_MASK: rdata_d[1:0] = msk_q;
        // result hidden while the block is in flight
        OFS_STATE: rdata_d[7:0] = busy ? 8'h00 : st_byte; // see RULE_04
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      dp_vld_q <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_adr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      dp_vld_q <= dp_vld_d;
      dp_wr_q <= dp_wr_d;
      dp_adr_q <= dp_adr_d;
      rdata_q <= rdata_d;
    end
  end

  // modes, sticky events, mask and trigger
  always_comb begin
    dec_d = dec_q;
    auto_d = auto_q;
    xor_d = xor_q;
    msk_d = msk_q;
    // mode changes are refused mid-operation
    if (wr_ctrl && !busy) begin
      dec_d = HWDATA_IN[CTRL_DEC_BIT];
      auto_d = HWDATA_IN[CTRL_AUTO_BIT];
      xor_d = HWDATA_IN[CTRL_XOR_BIT];
    end
    if (wr_msk) msk_d = HWDATA_IN[1:0];
    // set wins over a write-one clear in the same cycle
    ev_d = ev_q & ~(wr_sts ? HWDATA_IN[1:0] : 2'b00);
    ev_d[EV_DONE_BIT] = ev_d[EV_DONE_BIT] | done_ev; // see RULE_04
    ev_d[EV_ERR_BIT] = ev_d[EV_ERR_BIT] | err_ev;
    trig_d = done_ev; // see RULE_05
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      dec_q <= CTRL_RST;
      auto_q <= CTRL_RST;
      xor_q <= CTRL_RST;
      ev_q <= EV_RST;
      msk_q <= MASK_RST;
      trig_q <= 1'b0;
    end else begin
      dec_q <= dec_d;
      auto_q <= auto_d;
      xor_q <= xor_d;
      ev_q <= ev_d;
      msk_q <= msk_d;
      trig_q <= trig_d;
    end
  end

  // memories, pointers and the round sequencer
  always_comb begin
    fsm_d = fsm_q;
    st_d = st_q;
    key_d = key_q;
    rk_d = rk_q;
    rnd_d = rnd_q;
    sp_d = sp_q;
    kp_d = kp_q;
    cyc_d = busy ? cyc_q + 9'h001 : cyc_q;
    run_dec_d = run_dec_q;
    if (!busy) begin
      // a control write rewinds both ports
      if (wr_ctrl) begin
        sp_d = 4'h0;
        kp_d = 4'h0;
      end
      if (wr_st) begin
        st_d[{~sp_q, 3'b000} +: 8] = xor_q ? xor_byte
                                          : HWDATA_IN[7:0]; // see RULE_07
        sp_d = sp_q + 4'h1; // see RULE_08
      end else if (rd_st) begin
        sp_d = sp_q + 4'h1; // see RULE_08
      end
      if (wr_key) begin
        key_d[{~kp_q, 3'b000} +: 8] = HWDATA_IN[7:0];
        kp_d = kp_q + 4'h1; // see RULE_08
      end
    end
    case (fsm_q)
      S_IDLE: begin
        // memories are taken as loaded; the byte written now counts
        if (go) begin // see RULE_02
          cyc_d = 9'h000;
          rk_d = key_q;
          rnd_d = FIRST_ROUND;
          sp_d = 4'h0;
          run_dec_d = go_dec;
          if (go_dec) begin
            fsm_d = S_KEYX;
          end else begin
            st_d = st_d ^ key_q; // see RULE_01
            fsm_d = S_RUN;
          end
        end
      end
      S_KEYX: begin
        // decryption first walks the schedule forward to the last key
        rk_d = rk_fwd;
        rnd_d = rnd_q + 4'h1;
        if (rnd_q == LAST_ROUND) begin
          st_d = st_q ^ rk_fwd; // see RULE_01
          rnd_d = LAST_ROUND;
          fsm_d = S_RUN;
        end
      end
      S_RUN: begin
        st_d = rnd_out; // see RULE_01
        rk_d = rk_nx;
        rnd_d = run_dec_q ? rnd_q - 4'h1 : rnd_q + 4'h1;
        if (last) fsm_d = S_HOLD;
      end
      S_HOLD: begin
        // pad to the fixed latency so software timing is exact
        if (cyc_q == OP_LAST) begin // see RULE_03
          fsm_d = S_IDLE;
          sp_d = 4'h0; // see RULE_04
        end
      end
      default: fsm_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      fsm_q <= S_IDLE;
      st_q <= 128'h0;
      key_q <= 128'h0;
      rk_q <= 128'h0;
      rnd_q <= 4'h0;
      sp_q <= 4'h0;
      kp_q <= 4'h0;
      cyc_q <= 9'h000;
      run_dec_q <= 1'b0;
    end else begin
      fsm_q <= fsm_d;
      st_q <= st_d;
      key_q <= key_d;
      rk_q <= rk_d;
      rnd_q <= rnd_d;
      sp_q <= sp_d;
      kp_q <= kp_d;
      cyc_q <= cyc_d;
      run_dec_q <= run_dec_d;
    end
  end

  // zero wait states, always okay
  assign HRDATA_OUT = rdata_q;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = HRESP_OKAY;
  assign IRQ_OUT = |(ev_q & msk_q); // see RULE_04
  assign DMA_TRIG_OUT = trig_q; // see RULE_05

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  property p_op_time;
    go |-> ##[375:375] done_ev;
  endproperty
  a_op_time: assert property (p_op_time) // see RULE_03
    else $error("completion not 375 cycles after start");

  property p_mode_hold;
    busy && !done_ev |=>
      run_dec_q == $past(run_dec_q) && key_q == $past(key_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold) // see RULE_01
    else $error("direction or key changed mid-operation");

  property p_result;
    done_ev |=> !busy && ev_q[EV_DONE_BIT] && sp_q == 4'h0;
  endproperty
  a_result: assert property (p_result) // see RULE_04
    else $error("result not presented on completion");

  property p_irq;
    done_ev && msk_q[EV_DONE_BIT] && !wr_msk |=> IRQ_OUT;
  endproperty
  a_irq: assert property (p_irq) // see RULE_04
    else $error("enabled completion gave no interrupt");

  property p_dma;
    done_ev |=> DMA_TRIG_OUT ##1 !DMA_TRIG_OUT;
  endproperty
  a_dma: assert property (p_dma) // see RULE_05
    else $error("dma trigger not a single pulse");

  property p_auto;
    !busy && auto_q && wr_st && sp_q == 4'hf |=> busy && cyc_q == 9'h000;
  endproperty
  a_auto: assert property (p_auto) // see RULE_06
    else $error("auto start missed");

  property p_xor;
    !busy && xor_q && wr_st && !go |=>
      st_q[{~$past(sp_q), 3'b000} +: 8] == $past(xor_byte);
  endproperty
  a_xor: assert property (p_xor) // see RULE_07
    else $error("xor load wrong");

  property p_ptr;
    !busy && (wr_st || rd_st) && !go && !wr_ctrl |=>
      sp_q == $past(sp_q) + 4'h1;
  endproperty
  a_ptr: assert property (p_ptr) // see RULE_08
    else $error("state pointer did not advance");

  c_enc: cover property (done_ev && !run_dec_q);
  c_dec: cover property (done_ev && run_dec_q);
  c_auto: cover property (go && wr_st);
  c_xor: cover property (!busy && xor_q && wr_st);
endmodule : aesc_top
`default_nettype wire

// File: common/aesc_pkg.sv
// constants, state type and field arithmetic for the aes block engine
`default_nettype none
package aesc_pkg;
  localparam int BUS_W = 32; // ahb data width
  localparam int OP_CYCLES = 375; // start to completion, in clock cycles
  localparam logic [8:0] OP_LAST = 9'(OP_CYCLES - 1); // last busy cycle
  localparam logic [3:0] FIRST_ROUND = 4'h1;
  localparam logic [3:0] LAST_ROUND = 4'ha;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_KEY = 8'h10;
  // control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DEC_BIT = 1;
  localparam int CTRL_AUTO_BIT = 2;
  localparam int CTRL_XOR_BIT = 3;
  localparam logic CTRL_RST = 1'b0; // reset value of each mode bit
  // status and mask fields, same layout
  localparam int EV_DONE_BIT = 0;
  localparam int EV_ERR_BIT = 1;
  localparam int STS_BUSY_BIT = 8;
  localparam logic [1:0] EV_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  // bus encodings
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  // affine constants of the substitution box and the field polynomial
  localparam logic [7:0] AFF_FWD_C = 8'h63;
  localparam logic [7:0] AFF_INV_C = 8'h05;
  localparam logic [7:0] GF_POLY = 8'h1b;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_KEYX = 4'b0010,
    S_RUN = 4'b0100,
    S_HOLD = 4'b1000
  } aesc_state_t;

  function automatic logic [7:0] xtime(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
  endfunction : xtime

  function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xtime(x);
    end
    return p;
  endfunction : gf_mul

  // a^254; maps zero to zero as the cipher expects
  function automatic logic [7:0] gf_inv(input logic [7:0] a);
    logic [7:0] p;
    logic [7:0] r;
    p = a;
    r = 8'h01;
    for (int i = 1; i < 8; i++) begin
      p = gf_mul(p, p);
      r = gf_mul(r, p);
    end
    return r;
  endfunction : gf_inv

  function automatic logic [7:0] rcon(input logic [3:0] idx);
    case (idx)
      4'h1: return 8'h01;
      4'h2: return 8'h02;
      4'h3: return 8'h04;
      4'h4: return 8'h08;
      4'h5: return 8'h10;
      4'h6: return 8'h20;
      4'h7: return 8'h40;
      4'h8: return 8'h80;
      4'h9: return 8'h1b;
      4'ha: return 8'h36;
      default: return 8'h00;
    endcase
  endfunction : rcon
endpackage : aesc_pkg
`default_nettype wire

// File: hdl/aesc_sbox.sv
// forward or inverse substitution of one byte, computed not tabled
`timescale 1ns/1ns
`default_nettype none
module aesc_sbox (
  input wire logic [7:0] byte_in,
  input wire logic inv_in,
  output logic [7:0] byte_out
);
  import aesc_pkg::*;

  // rotate left; logic beats a 256-entry table on area
  function automatic logic [7:0] rl(input logic [7:0] a, input int n);
    return (a << n) | (a >> (8 - n));
  endfunction : rl

  logic [7:0] fwd_inv; // field inverse for the forward path
  logic [7:0] inv_aff; // inverse affine for the inverse path

  assign fwd_inv = gf_inv(byte_in);
  assign inv_aff = rl(byte_in, 1) ^ rl(byte_in, 3) ^ rl(byte_in, 6) ^
                   AFF_INV_C;

  // select path by direction
  always_comb begin
    if (inv_in) begin
      byte_out = gf_inv(inv_aff);
    end else begin
      byte_out = fwd_inv ^ rl(fwd_inv, 1) ^ rl(fwd_inv, 2) ^
                 rl(fwd_inv, 3) ^ rl(fwd_inv, 4) ^ AFF_FWD_C;
    end
  end
endmodule : aesc_sbox
`default_nettype wire

// File: hdl/aesc_round.sv
// one full cipher round, forward or inverse, in one cycle
`timescale 1ns/1ns
`default_nettype none
module aesc_round (
  input wire logic [127:0] state_in,
  input wire logic [127:0] key_in,
  input wire logic dec_in,
  input wire logic last_in,
  output logic [127:0] state_out
);
  import aesc_pkg::*;

  logic [7:0] sb [16]; // substituted bytes
  logic [7:0] sh [16]; // after row shift
  logic [7:0] pb [16]; // column mix input
  logic [7:0] mb [16]; // column mix output

  // bytewise substitution commutes with the row shift
  for (genvar i = 0; i < 16; i++) begin : g_sub
    aesc_sbox u_sbox (
      .byte_in(state_in[127-8*i -: 8]),
      .inv_in(dec_in),
      .byte_out(sb[i])
    );
  end

  // byte 4c+r is row r of column c
  for (genvar c = 0; c < 4; c++) begin : g_col
    for (genvar r = 0; r < 4; r++) begin : g_row
      localparam int I = 4*c + r;
      localparam int B1 = 4*c + (r+1)%4;
      localparam int B2 = 4*c + (r+2)%4;
      localparam int B3 = 4*c + (r+3)%4;
      assign sh[I] = dec_in ? sb[4*((c+4-r)%4)+r] : sb[4*((c+r)%4)+r];
      // inverse round adds the key before unmixing
      assign pb[I] = dec_in ? (sh[I] ^ key_in[127-8*I -: 8]) : sh[I];
      assign mb[I] = dec_in ?
        (gf_mul(pb[I], 8'h0e) ^ gf_mul(pb[B1], 8'h0b) ^
         gf_mul(pb[B2], 8'h0d) ^ gf_mul(pb[B3], 8'h09)) :
        (xtime(pb[I]) ^ xtime(pb[B1]) ^ pb[B1] ^ pb[B2] ^ pb[B3]);
      // final round skips the column mix
      assign state_out[127-8*I -: 8] = dec_in ?
        (last_in ? pb[I] : mb[I]) :
        ((last_in ? pb[I] : mb[I]) ^ key_in[127-8*I -: 8]);
    end
  end
endmodule : aesc_round
`default_nettype wire

// File: verif/aesc_ahb_master.sv
// ahb-lite master model standing in for the cpu or dma controller
`timescale 1ns/1ns
`default_nettype none
module aesc_ahb_master (
  input wire logic clk_in,
  input wire logic [aesc_pkg::BUS_W-1:0] hrdata_in,
  input wire logic hready_in,
  output logic hsel_out,
  output logic [aesc_pkg::BUS_W-1:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [aesc_pkg::BUS_W-1:0] hwdata_out
);
  import aesc_pkg::*;
  // idle bus from time zero; select stays up, htrans idle marks no transfer
  initial begin
    hsel_out = 1'b1;
    haddr_out = '0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = SIZE_WORD;
    hwdata_out = '0;
  end
  // one single word transfer, entered just after a rising edge
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
    hsel_out <= 1'b1;
    haddr_out <= {24'h000000, a};
    htrans_out <= 2'h2;
    hwrite_out <= w;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    htrans_out <= 2'h0;
    hwdata_out <= d;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    q = hrdata_in;
    // released data must not keep looking valid
    hwdata_out <= ~d;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h00000000, q);
  endtask : rd
  // whole block, leftmost byte first, one byte per access
  task automatic ld(input logic [7:0] a, input logic [127:0] blk);
    for (int i = 0; i < 16; i++) begin
      wr(a, {24'h000000, blk[127-8*i -: 8]});
    end
  endtask : ld
endmodule : aesc_ahb_master
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the aes block engine
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import aesc_pkg::*;
  localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
  localparam logic [127:0] PT = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] CT = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
  localparam logic [127:0] PAT = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  localparam int LAT = OP_CYCLES + 1; // trigger in the cycle after busy
  logic core_clk;
  logic rst_b;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic irq;
  logic dma;
  int error_cnt;
  int n_tests;
  int cyc; // free-running cycle count
  int s; // cycle count at start
  aesc_top dut (.CORE_CLK_IN(core_clk), .RST_B_IN(rst_b), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .IRQ_OUT(irq), .DMA_TRIG_OUT(dma));
  aesc_ahb_master m (.clk_in(core_clk), .hrdata_in(hrdata),
    .hready_in(hready), .hsel_out(hsel), .haddr_out(haddr),
    .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
    .hwdata_out(hwdata));
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;
  // cycle count and hang guard; whole run needs about 1400 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      $display("MISMATCH timeout");
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic cmp32(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask : cmp32
  task automatic cmp128(string nm, logic [127:0] e, logic [127:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask : cmp128
  // sixteen state reads give the block back, leftmost byte first
  task automatic get_blk(output logic [127:0] b);
    logic [31:0] q;
    b = '0;
    for (int i = 0; i < 16; i++) begin
      m.rd(OFS_STATE, q);
      b = {b[119:0], q[7:0]};
    end
  endtask : get_blk
  // bounded wait for the trigger, then latency and pulse width
  task automatic wait_done();
    #1;
    while (dma !== 1'b1 && cyc - s < 600) begin
      @(posedge core_clk);
      #1;
    end
    cmp32("latency", 32'(LAT), 32'(cyc - s));
    cmp32("dma_hi", 32'h1, {31'h0, dma});
    @(posedge core_clk);
    #1;
    cmp32("dma_lo", 32'h0, {31'h0, dma});
  endtask : wait_done
  // reset values, unmapped place, mask access, write-only key port
  task automatic t_reset();
    logic [31:0] q;
    cmp32("irq", 32'h0, {31'h0, irq});
    cmp32("dma", 32'h0, {31'h0, dma});
    cmp32("hresp", 32'h0, {31'h0, hresp});
    m.rd(OFS_STATUS, q);
    cmp32("status", 32'h0, q);
    m.wr(8'h20, 32'hffffffff);
    m.rd(8'h20, q);
    cmp32("unmapped", 32'h0, q);
    m.rd(OFS_MASK, q);
    cmp32("mask_rst", 32'h0, q);
    m.wr(OFS_MASK, 32'h3);
    m.rd(OFS_MASK, q);
    cmp32("mask", 32'h3, q);
    m.rd(OFS_KEY, q);
    cmp32("key_rd", 32'h0, q);
  endtask : t_reset
  // encrypt by explicit start, done interrupt enabled
  task automatic t_encrypt();
    logic [31:0] q;
    logic [127:0] b;
    m.wr(OFS_CTRL, 32'h0);
    m.ld(OFS_KEY, KEY);
    m.ld(OFS_STATE, PT);
    m.wr(OFS_MASK, 32'h1);
    m.wr(OFS_CTRL, 32'h1);
    s = cyc;
    m.rd(OFS_STATUS, q);
    cmp32("busy", 32'h100, q);
    wait_done();
    cmp32("irq_done", 32'h1, {31'h0, irq});
    m.rd(OFS_STATUS, q);
    cmp32("status_done", 32'h1, q);
    get_blk(b);
    cmp128("cipher", CT, b);
    m.wr(OFS_STATUS, 32'h1);
    #1;
    cmp32("irq_clr", 32'h0, {31'h0, irq});
  endtask : t_encrypt
  // decrypt with the kept key; accesses while busy are refused
  task automatic t_decrypt();
    logic [31:0] q;
    logic [127:0] b;
    m.wr(OFS_MASK, 32'h2);
    m.wr(OFS_CTRL, 32'h3);
    s = cyc;
    m.wr(OFS_STATE, 32'h55);
    m.rd(OFS_STATE, q);
    cmp32("busy_rd", 32'h0, q);
    #1;
    cmp32("irq_err", 32'h1, {31'h0, irq});
    wait_done();
    m.rd(OFS_STATUS, q);
    cmp32("status_err", 32'h3, q);
    get_blk(b);
    cmp128("plain", PT, b);
    m.wr(OFS_STATUS, 32'h3);
    #1;
    cmp32("irq_clr2", 32'h0, {31'h0, irq});
  endtask : t_decrypt
  // xor load of the last block starts the cipher by itself
  task automatic t_xor_auto();
    logic [31:0] q;
    logic [127:0] b;
    m.wr(OFS_CTRL, 32'h0);
    m.ld(OFS_STATE, PT ^ PAT);
    m.wr(OFS_CTRL, 32'hc);
    m.ld(OFS_STATE, PAT);
    s = cyc;
    wait_done();
    cmp32("irq_mask", 32'h0, {31'h0, irq});
    m.rd(OFS_STATUS, q);
    cmp32("status_auto", 32'h1, q);
    get_blk(b);
    cmp128("xor_cipher", CT, b);
  endtask : t_xor_auto
  // reset for two cycles, then each scenario in turn
  initial begin
    rst_b = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    s = 0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_encrypt();
    t_decrypt();
    t_xor_auto();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
